/* File: core/ile_load_unit.sv */
// integer load execution: address generation, memory request, result and base writeback
// How it works
// RULE_01: indexed forms add base-or-zero and index register for the address
// RULE_02: displacement forms add the sign-extended displacement to the base content
// RULE_03: zero half-word load puts data in bits 16..31, clears the rest
// RULE_04: algebraic half-word load fills upper bits with half-word bit 0
// RULE_05: word load places the whole memory word in bits 0..31
// RULE_06: update forms also write the effective address into the base register
// RULE_07: update with base field zero writes the address into general_reg_zero
// RULE_08: base equal to destination ends holding the loaded memory value
// RULE_09: base field zero means constant zero where base-or-zero applies; the code reads the register for the plain algebraic form ILE_HA
// RULE_10: bit 0 is the most significant bit everywhere; the code numbers the register selectors with bit 0 as the lsb
`timescale 1ns/10ps
module ile_load_unit
  import ile_pkg::*;
(
  // clock and reset
  input logic mclk,
  input logic rst,
  // instruction issue
  input logic cmdValid,
  input ile_pkg::ile_op_t cmdOp,
  input logic [ile_pkg::SEL_W-1:0] cmdDest,
  input logic [ile_pkg::SEL_W-1:0] cmdBase,
  input logic [ile_pkg::SEL_W-1:0] cmdIndex,
  input logic [0:ile_pkg::DISP_W-1] cmdDisp,
  output logic busy_r,
  output logic done_r,
  // memory side
  output logic memReq_r,
  output logic memWord_r,
  output logic [0:ile_pkg::WORD_W-1] memAddr_r,
  input logic memAck,
  input logic [0:ile_pkg::WORD_W-1] memRdData,
  // register file access from other units
  input logic extWrEn,
  input logic [ile_pkg::SEL_W-1:0] extWrSel,
  input logic [0:ile_pkg::WORD_W-1] extWrData,
  input logic [ile_pkg::SEL_W-1:0] dbgSel,
  output logic [0:ile_pkg::WORD_W-1] dbgData_r
);
  import ile_pkg::*;

  // big-endian data words throughout, index 0 is the msb
  logic [0:WORD_W-1] gpr [0:GPR_COUNT-1]; // RULE_10
  ile_state_t state_r;
  ile_op_t op_r;
  logic [SEL_W-1:0] dest_r;
  logic [SEL_W-1:0] base_r;
  logic [0:WORD_W-1] ea_r;

  logic take;
  logic isIndexed;
  logic isUpdate;
  logic isWord;
  logic isSigned;
  logic useRawBase;
  logic [0:WORD_W-1] baseVal;
  logic [0:WORD_W-1] indexVal;
  logic [0:WORD_W-1] dispExt;
  logic [0:WORD_W-1] eaNxt;
  logic [0:WORD_W-1] loadVal;
  logic opUpdate;
  logic opWord;
  logic opSigned;

  assign take = cmdValid && (state_r == ILE_IDLE);

  always_comb
  begin
    isIndexed = 1'b0;
    isUpdate = 1'b0;
    isWord = 1'b0;
    isSigned = 1'b0;
    useRawBase = 1'b0;
    unique case (cmdOp)
      ILE_HZUX:
      begin
        isIndexed = 1'b1;
        isUpdate = 1'b1;
      end
      ILE_HA:
      begin
        isSigned = 1'b1;
        useRawBase = 1'b1;
      end
      ILE_HAX:
      begin
        isSigned = 1'b1;
        isIndexed = 1'b1;
      end
      ILE_HAU:
      begin
        isSigned = 1'b1;
        isUpdate = 1'b1;
      end
      ILE_HAUX:
      begin
        isSigned = 1'b1;
        isIndexed = 1'b1;
        isUpdate = 1'b1;
      end
      ILE_WZ: isWord = 1'b1;
      ILE_WZX:
      begin
        isWord = 1'b1;
        isIndexed = 1'b1;
      end
      ILE_WZU:
      begin
        isWord = 1'b1;
        isUpdate = 1'b1;
      end
      ILE_WZUX:
      begin
        isWord = 1'b1;
        isIndexed = 1'b1;
        isUpdate = 1'b1;
      end
      default:
      begin
        isWord = 1'b1;
      end
    endcase
  end

  // plain algebraic form reads the register even when the field is zero
  assign baseVal = (cmdBase == ZERO_SEL && !useRawBase) ? WORD_RST : gpr[cmdBase]; // RULE_09
  assign indexVal = gpr[cmdIndex];
  assign dispExt = {{HALF_W{cmdDisp[0]}}, cmdDisp}; // RULE_10
  assign eaNxt = isIndexed ? baseVal + indexVal : baseVal + dispExt; // RULE_01 RULE_02

  assign opUpdate = (op_r == ILE_HZUX) || (op_r == ILE_HAU) || (op_r == ILE_HAUX)
    || (op_r == ILE_WZU) || (op_r == ILE_WZUX);
  assign opWord = (op_r == ILE_WZ) || (op_r == ILE_WZX) || (op_r == ILE_WZU)
    || (op_r == ILE_WZUX);
  assign opSigned = (op_r == ILE_HA) || (op_r == ILE_HAX) || (op_r == ILE_HAU)
    || (op_r == ILE_HAUX);

  always_comb
  begin
    if (opWord)
      loadVal = memRdData; // RULE_05
    else if (opSigned && memRdData[HALF_LSB_POS])
      loadVal = {HALF_ONES, memRdData[HALF_LSB_POS:WORD_W-1]}; // RULE_04
    else
      loadVal = {HALF_ZERO, memRdData[HALF_LSB_POS:WORD_W-1]}; // RULE_03
  end

  // sequencing
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_r <= ILE_IDLE;
    else
      unique case (state_r)
        ILE_IDLE: if (take) state_r <= ILE_WAIT;
        ILE_WAIT: if (memAck) state_r <= ILE_DONE;
        ILE_DONE: state_r <= ILE_IDLE;
      endcase
  end

  // captured instruction fields
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      op_r <= ILE_WZ;
      dest_r <= ZERO_SEL;
      base_r <= ZERO_SEL;
      ea_r <= WORD_RST;
    end
    else if (take)
    begin
      op_r <= cmdOp;
      dest_r <= cmdDest;
      base_r <= cmdBase;
      ea_r <= eaNxt;
    end
  end

  // memory request held until acknowledged
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      memReq_r <= 1'b0;
      memWord_r <= 1'b0;
      memAddr_r <= WORD_RST;
    end
    else if (take)
    begin
      memReq_r <= 1'b1;
      memWord_r <= isWord;
      memAddr_r <= eaNxt;
    end
    else if (memAck)
      memReq_r <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      busy_r <= take || (busy_r && !(state_r == ILE_WAIT && memAck));
      done_r <= (state_r == ILE_WAIT) && memAck;
    end
  end

  // register file; the destination write comes last so it wins on overlap
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < GPR_COUNT; i++)
        gpr[i] <= WORD_RST;
    end
    else if (state_r == ILE_WAIT && memAck)
    begin
      if (opUpdate)
        gpr[base_r] <= ea_r; // RULE_06 RULE_07
      gpr[dest_r] <= loadVal; // RULE_08
    end
    else if (extWrEn && !busy_r)
      gpr[extWrSel] <= extWrData;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dbgData_r <= WORD_RST;
    else
      dbgData_r <= gpr[dbgSel];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ea_index_a: assert property (take && isIndexed |=> // RULE_01
    memAddr_r == $past(baseVal) + $past(indexVal))
    else $error("indexed address wrong");
  ea_disp_a: assert property (take && !isIndexed |=> // RULE_02
    memAddr_r == $past(baseVal) + $past(dispExt))
    else $error("displacement address wrong");
  zero_base_a: assert property (take && cmdBase == ZERO_SEL && isIndexed // RULE_09
    && !useRawBase |=> memAddr_r == $past(indexVal))
    else $error("base field zero not treated as zero");
  half_zero_a: assert property (state_r == ILE_WAIT && memAck && !opWord // RULE_03
    && !opSigned |=>
    gpr[dest_r] == {HALF_ZERO, $past(memRdData[HALF_LSB_POS:WORD_W-1])})
    else $error("zero half-word result wrong");
  half_sign_a: assert property (state_r == ILE_WAIT && memAck && opSigned |=> // RULE_04
    gpr[dest_r][0:HALF_W-1] == {HALF_W{$past(memRdData[HALF_LSB_POS])}})
    else $error("algebraic fill wrong");
  word_load_a: assert property (state_r == ILE_WAIT && memAck && opWord |=> // RULE_05
    gpr[dest_r] == $past(memRdData))
    else $error("word result wrong");
  base_update_a: assert property (done_r && opUpdate && base_r != dest_r |-> // RULE_06
    gpr[base_r] == ea_r)
    else $error("base not updated");
  reg_zero_a: assert property (done_r && opUpdate && base_r == ZERO_SEL // RULE_07
    && dest_r != ZERO_SEL |-> gpr[0] == ea_r)
    else $error("address not written to register zero");
  overlap_a: assert property (state_r == ILE_WAIT && memAck && opUpdate // RULE_08
    && base_r == dest_r |=> gpr[dest_r] == $past(loadVal) && done_r)
    else $error("overlap did not keep memory value");
  req_hold_a: assert property (memReq_r && !memAck |=> memReq_r)
    else $error("request dropped before acknowledge");

  idx_upd_c: cover property (take && isIndexed && isUpdate ##[1:20] done_r);
  zero_upd_c: cover property (done_r && opUpdate && base_r == ZERO_SEL);
  overlap_c: cover property (done_r && opUpdate && base_r == dest_r);
  neg_half_c: cover property (state_r == ILE_WAIT && memAck && opSigned
    && memRdData[HALF_LSB_POS]);

endmodule : ile_load_unit

/* File: core/ile_pkg.sv */
// shared constants and types for the integer load execution block
package ile_pkg;

  localparam int GPR_COUNT = 32;
  localparam int SEL_W = 5;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int DISP_W = 16;
  // first bit of the half-word element on the read bus, big-endian numbering
  localparam int HALF_LSB_POS = 16;
  localparam logic [SEL_W-1:0] ZERO_SEL = 5'h00;
  localparam logic [0:WORD_W-1] WORD_RST = 32'h00000000;
  localparam logic [0:HALF_W-1] HALF_ZERO = 16'h0000;
  localparam logic [0:HALF_W-1] HALF_ONES = 16'hFFFF;

  // supported load forms
  typedef enum logic [3:0] {
    ILE_HZUX,
    ILE_HA,
    ILE_HAX,
    ILE_HAU,
    ILE_HAUX,
    ILE_WZ,
    ILE_WZX,
    ILE_WZU,
    ILE_WZUX
  } ile_op_t;

  typedef enum logic [1:0] {
    ILE_IDLE,
    ILE_WAIT,
    ILE_DONE
  } ile_state_t;

endpackage : ile_pkg

/* File: test/ile_mem_model.sv */
// memory model answering load requests after a chosen delay
`timescale 1ns/10ps
module ile_mem_model #(parameter logic [0:31] PATTERN = 32'h5A3C96F0)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request side
  input wire logic memReq_r,
  input wire logic memWord_r,
  input wire logic [0:31] memAddr_r,
  input wire logic [3:0] ackDelay,
  // answer side
  output logic memAck,
  output logic [0:31] memRdData
);
  logic [3:0] waitCnt_r;
  logic [0:31] word;
  logic fire;
  // contents derived from the address, so no storage is needed
  assign word = memAddr_r ^ PATTERN;
  assign fire = memReq_r && !memAck && (waitCnt_r == ackDelay);
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      memAck <= 1'b0;
      waitCnt_r <= 4'h0;
      memRdData <= 32'h00000000;
    end
    else
    begin
      memAck <= fire;
      waitCnt_r <= (memReq_r && !memAck && !fire) ? waitCnt_r + 4'h1 : 4'h0;
      // idle cycles show inverted data so stale values never match
      memRdData <= !fire ? ~word : memWord_r ? word : {~word[16:31], word[16:31]};
    end
  end
endmodule : ile_mem_model

/* File: test/tb.sv */
// self-checking bench for the integer load unit
`timescale 1ns/10ps
module tb;
  import ile_pkg::*;
  localparam logic [0:31] PAT = 32'h5A3C96F0;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0;
  logic extWrEn = 1'b0;
  ile_op_t cmdOp = ILE_HZUX;
  logic [SEL_W-1:0] cmdDest = 5'h00, cmdBase = 5'h00, cmdIndex = 5'h00;
  logic [SEL_W-1:0] dbgSel = 5'h00, extWrSel = 5'h00;
  logic [0:DISP_W-1] cmdDisp = 16'h0000;
  logic [0:WORD_W-1] extWrData = 32'h00000000;
  logic [3:0] ackDelay = 4'h0;
  logic busy_r, done_r, memReq_r, memWord_r, memAck;
  logic [0:WORD_W-1] memAddr_r, memRdData, dbgData_r, got;
  logic [0:WORD_W-1] gpr [GPR_COUNT];
  int fails = 0;
  int total_checks = 0;
  ile_load_unit ile_load_unit_inst (.mclk(mclk), .rst(rst), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdDest(cmdDest), .cmdBase(cmdBase), .cmdIndex(cmdIndex),
    .cmdDisp(cmdDisp), .busy_r(busy_r), .done_r(done_r), .memReq_r(memReq_r),
    .memWord_r(memWord_r), .memAddr_r(memAddr_r), .memAck(memAck),
    .memRdData(memRdData), .extWrEn(extWrEn), .extWrSel(extWrSel),
    .extWrData(extWrData), .dbgSel(dbgSel), .dbgData_r(dbgData_r));
  ile_mem_model #(.PATTERN(PAT)) ile_mem_model_inst (.mclk(mclk), .rst(rst),
    .memReq_r(memReq_r), .memWord_r(memWord_r), .memAddr_r(memAddr_r),
    .ackDelay(ackDelay), .memAck(memAck), .memRdData(memRdData));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task automatic summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask : summarize
  task automatic chk(input logic [0:31] g, input logic [0:31] e);
    begin
      total_checks++;
      if (g !== e)
      begin
        fails++;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask : chk
  // bounded wait for memReq_r (0) or done_r (1)
  task automatic waitFor(input bit w);
    begin
      for (int i = 0; i < 40; i++)
      begin
        #1;
        if ((w ? done_r : memReq_r) === 1'b1)
          return;
        @(posedge mclk);
      end
      fails++;
      summarize;
    end
  endtask : waitFor
  task automatic setReg(input logic [4:0] s, input logic [0:31] v);
    begin
      @(posedge mclk);
      extWrEn <= 1'b1;
      extWrSel <= s;
      extWrData <= v;
      @(posedge mclk);
      extWrEn <= 1'b0;
      gpr[s] = v;
    end
  endtask : setReg
  task automatic getReg(input logic [4:0] s);
    begin
      @(posedge mclk);
      dbgSel <= s;
      @(posedge mclk);
      #1;
      got = dbgData_r;
    end
  endtask : getReg
  task automatic runLoad(input ile_op_t op, input logic [4:0] d, b, x,
      input logic [0:15] dp, input logic [3:0] dly);
    logic [0:31] ea, w, val, bv;
    bit upd;
    begin
      bv = (b == ZERO_SEL && op != ILE_HA) ? WORD_RST : gpr[b];
      ea = bv + (op inside {ILE_HA, ILE_HAU, ILE_WZ, ILE_WZU} ? {{16{dp[0]}}, dp} : gpr[x]);
      w = ea ^ PAT;
      val = op >= ILE_WZ ? w : {(op == ILE_HZUX) ? HALF_ZERO : {16{w[16]}}, w[16:31]};
      upd = op inside {ILE_HZUX, ILE_HAU, ILE_HAUX, ILE_WZU, ILE_WZUX};
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdOp <= op;
      cmdDest <= d;
      cmdBase <= b;
      cmdIndex <= x;
      cmdDisp <= dp;
      ackDelay <= dly;
      @(posedge mclk);
      cmdValid <= 1'b0;
      waitFor(1'b0);
      chk(memAddr_r, ea);
      chk({31'h0, memWord_r}, {31'h0, op >= ILE_WZ});
      chk({31'h0, busy_r}, 32'h00000001);
      if (dly == 4'h8)
      begin
        // write attempt while busy must be dropped
        @(posedge mclk);
        extWrEn <= 1'b1;
        extWrSel <= 5'h09;
        extWrData <= 32'hDEADBEEF;
        @(posedge mclk);
        extWrEn <= 1'b0;
      end
      waitFor(1'b1);
      if (upd)
        gpr[b] = ea;
      gpr[d] = val;
      getReg(d);
      chk(got, val);
      getReg(b);
      chk(got, gpr[b]);
    end
  endtask : runLoad
  task automatic testReset;
    begin
      getReg(5'h1F);
      chk(got, WORD_RST);
      chk({31'h0, busy_r | memReq_r | done_r}, 32'h00000000);
      $display("test reset done");
    end
  endtask : testReset
  task automatic testForms;
    begin
      setReg(5'h03, 32'h00001230);
      setReg(5'h04, 32'h00008006);
      for (int i = 0; i < 9; i++)
        runLoad(ile_op_t'(i), 5'h07, 5'h03, 5'h04, 16'hFFF8, 4'(i % 3));
      $display("test forms done");
    end
  endtask : testForms
  task automatic testZeroBase;
    begin
      setReg(5'h00, 32'h40000000);
      runLoad(ILE_HZUX, 5'h08, 5'h00, 5'h04, 16'h0000, 4'h1);
      runLoad(ILE_HA, 5'h09, 5'h00, 5'h00, 16'h0010, 4'h0);
      runLoad(ILE_WZU, 5'h0A, 5'h00, 5'h00, 16'h0100, 4'h2);
      $display("test zero base done");
    end
  endtask : testZeroBase
  task automatic testOverlap;
    begin
      runLoad(ILE_WZUX, 5'h05, 5'h05, 5'h04, 16'h0000, 4'h1);
      runLoad(ILE_HAU, 5'h06, 5'h06, 5'h00, 16'h7FFE, 4'h0);
      setReg(5'h09, 32'h11112222);
      runLoad(ILE_WZ, 5'h0B, 5'h03, 5'h00, 16'h0004, 4'h8);
      getReg(5'h09);
      chk(got, 32'h11112222);
      $display("test overlap and busy done");
    end
  endtask : testOverlap
  initial
  begin
    for (int i = 0; i < GPR_COUNT; i++)
      gpr[i] = WORD_RST;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    testReset;
    testForms;
    testZeroBase;
    testOverlap;
    summarize;
  end
endmodule : tb
